// File: common/i2cbg_pkg.sv
// constants, register map and state codes of the baud generator block
// assumes a 32-bit classic wishbone bus and a single 125 MHz clock
package i2cbg_pkg;

   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_CTRL = 12'hf52;
   localparam logic [11:0] IDX_RELOAD_HIGH = 12'hf53;
   localparam logic [11:0] IDX_RELOAD_LOW = 12'hf54;
   localparam logic [11:0] IDX_READBACK_SELECT_A_STATE = 12'hf55;
   localparam logic [11:0] IDX_READBACK_SELECT_A_CTRL = 12'hf56;

   // field positions
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int CTRL_IRQ_EN_BIT = 4;
   localparam int READBACK_SELECT_A_SELECT_BIT = 0;
   localparam int VIEW_SCL_BIT = 7;
   localparam int VIEW_SDA_BIT = 6;
   localparam int VIEW_STOP_BIT = 5;

   // reload reset value and count step
   localparam logic [7:0] RELOAD_BYTE_RST = 8'hff;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

   // serial state codes as seen in the diagnostic view
   typedef enum logic [4:0] {
      ST_IDLE = 5'h00, ST_START = 5'h01,
      ST_D7 = 5'h02, ST_D6 = 5'h03, ST_D5 = 5'h04, ST_D4 = 5'h05,
      ST_D3 = 5'h06, ST_D2 = 5'h07, ST_D1 = 5'h08, ST_D0 = 5'h09,
      ST_DACK = 5'h0a, ST_DNAK = 5'h0b, ST_STOP1 = 5'h0c, ST_STOP2 = 5'h0d,
      ST_AACK = 5'h0e, ST_ALSB = 5'h0f,
      ST_F7 = 5'h10, ST_F6 = 5'h11, ST_F5 = 5'h12, ST_F4 = 5'h13,
      ST_F3 = 5'h14, ST_F2 = 5'h15, ST_F1 = 5'h16, ST_FRW = 5'h17,
      ST_FACK = 5'h18,
      ST_A7 = 5'h19, ST_A6 = 5'h1a, ST_A5 = 5'h1b, ST_A4 = 5'h1c,
      ST_A3 = 5'h1d, ST_A2 = 5'h1e, ST_A1 = 5'h1f
   } i2cbg_fsm_t;

   typedef struct packed {
      logic [7:0] relHi;
      logic [7:0] relLo;
      logic ctrlEn;
      logic irqEn;
      logic diagSel;
      logic [15:0] count;
      logic tick;
      logic irq;
      logic [1:0] sclSync;
      logic [1:0] sdaSync;
      logic stopCount;
      i2cbg_fsm_t fsm;
      logic ack;
      logic [31:0] rdata;
   } i2cbg_state_t;

endpackage : i2cbg_pkg

// File: verilog/i2cbg_core.sv
// baud rate generator, general timer and diagnostic state view of the two-wire controller
// assumes a classic wishbone master on clk and raw line levels from the pads
module i2cbg_core
   import i2cbg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [15:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // line levels from the pads
   input wire logic clock_line_level,
   input wire logic data_line_level,
   // sequencing requests from the controller
   input wire logic startReq,
   input wire logic tenBitAddr,
   input wire logic stopReq,
   // to the controller and interrupt unit
   output logic controllerEnable,
   output logic baudTick,
   output logic timerIrq,
   output i2cbg_fsm_t serialFsmState
);

   i2cbg_state_t s_q;
   i2cbg_state_t s_d;

   function automatic logic hit(input logic [15:0] adr, input logic [11:0] idx);
      hit = (adr[15:2] == {2'b00, idx});
   endfunction : hit

   logic busReq;
   logic wrLane;
   logic [15:0] reloadValue;
   logic nack;

   assign busReq = cyc_i & stb_i & ~s_q.ack;
   assign wrLane = busReq & we_i & sel_i[0];
   assign reloadValue = {s_q.relHi, s_q.relLo};
   // not-acknowledge sampled as a high data line
   assign nack = s_q.sdaSync[1];

   always_comb begin
      s_d = s_q;
      // pads pass two flops before any use
      s_d.sclSync = {s_q.sclSync[0], clock_line_level};
      s_d.sdaSync = {s_q.sdaSync[0], data_line_level};

      // generator: count down, reload at one
      s_d.tick = 1'b0;
      s_d.irq = 1'b0;
      if (s_q.count <= COUNT_ONE) begin
         s_d.count = reloadValue;
         s_d.tick = 1'b1;
         // timer use only while the controller is off
         s_d.irq = s_q.irqEn & ~s_q.ctrlEn;
      end else begin
         s_d.count = s_q.count - COUNT_ONE;
      end

      // serial sequencer, one step per generator tick
      if (!s_q.ctrlEn) begin
         s_d.fsm = ST_IDLE;
         s_d.stopCount = 1'b0;
      end else if (s_q.tick) begin
         case (s_q.fsm)
            ST_IDLE: begin
               if (startReq) begin
                  s_d.fsm = ST_START;
               end
            end
            ST_START: begin
               s_d.fsm = tenBitAddr ? ST_F7 : ST_A7;
            end
            ST_F7, ST_F6, ST_F5, ST_F4, ST_F3, ST_F2, ST_F1,
            ST_A7, ST_A6, ST_A5, ST_A4, ST_A3, ST_A2,
            ST_D7, ST_D6, ST_D5, ST_D4, ST_D3, ST_D2, ST_D1: begin
               s_d.fsm = i2cbg_fsm_t'(s_q.fsm + 5'h01);
            end
            ST_FRW: begin
               s_d.fsm = ST_FACK;
            end
            ST_FACK: begin
               s_d.fsm = nack ? ST_STOP1 : ST_A7;
            end
            ST_A1: begin
               s_d.fsm = ST_ALSB;
            end
            ST_ALSB: begin
               s_d.fsm = ST_AACK;
            end
            ST_AACK: begin
               s_d.fsm = nack ? ST_STOP1 : ST_D7;
            end
            ST_D0: begin
               s_d.fsm = ST_DACK;
            end
            ST_DACK: begin
               if (nack) begin
                  s_d.fsm = ST_DNAK;
               end else if (stopReq) begin
                  s_d.fsm = ST_STOP1;
               end else begin
                  s_d.fsm = ST_D7;
               end
            end
            ST_DNAK: begin
               s_d.fsm = ST_STOP1;
            end
            ST_STOP1: begin
               s_d.fsm = ST_STOP2;
               s_d.stopCount = 1'b1;
            end
            ST_STOP2: begin
               s_d.fsm = ST_IDLE;
               s_d.stopCount = 1'b0;
            end
            default: begin
               s_d.fsm = ST_IDLE;
            end
         endcase
      end

      // wishbone: answer one cycle after the request
      s_d.ack = busReq;
      s_d.rdata = 32'h0000_0000;
      if (busReq && !we_i) begin
         if (hit(adr_i, IDX_RELOAD_HIGH)) begin
            s_d.rdata[7:0] = s_q.diagSel ? s_q.count[15:8] : s_q.relHi;
         end else if (hit(adr_i, IDX_RELOAD_LOW)) begin
            s_d.rdata[7:0] = s_q.diagSel ? s_q.count[7:0] : s_q.relLo;
         end else if (hit(adr_i, IDX_READBACK_SELECT_A_STATE)) begin
            s_d.rdata[VIEW_SCL_BIT] = s_q.sclSync[1];
            s_d.rdata[VIEW_SDA_BIT] = s_q.sdaSync[1];
            s_d.rdata[VIEW_STOP_BIT] = s_q.stopCount;
            s_d.rdata[4:0] = s_q.fsm;
         end else if (hit(adr_i, IDX_CTRL)) begin
            s_d.rdata[CTRL_ENABLE_BIT] = s_q.ctrlEn;
            s_d.rdata[CTRL_IRQ_EN_BIT] = s_q.irqEn;
         end else if (hit(adr_i, IDX_READBACK_SELECT_A_CTRL)) begin
            s_d.rdata[READBACK_SELECT_A_SELECT_BIT] = s_q.diagSel;
         end
      end
      // the diagnostic state view has no write path
      if (wrLane) begin
         if (hit(adr_i, IDX_RELOAD_HIGH)) begin
            s_d.relHi = dat_i[7:0];
         end
         if (hit(adr_i, IDX_RELOAD_LOW)) begin
            s_d.relLo = dat_i[7:0];
         end
         if (hit(adr_i, IDX_CTRL)) begin
            s_d.ctrlEn = dat_i[CTRL_ENABLE_BIT];
            s_d.irqEn = dat_i[CTRL_IRQ_EN_BIT];
         end
         if (hit(adr_i, IDX_READBACK_SELECT_A_CTRL)) begin
            s_d.diagSel = dat_i[READBACK_SELECT_A_SELECT_BIT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.relHi <= RELOAD_BYTE_RST;
         s_q.relLo <= RELOAD_BYTE_RST;
         s_q.count <= {RELOAD_BYTE_RST, RELOAD_BYTE_RST};
         s_q.fsm <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign dat_o = s_q.rdata;
   assign ack_o = s_q.ack;
   assign controllerEnable = s_q.ctrlEn;
   assign baudTick = s_q.tick;
   assign timerIrq = s_q.irq;
   assign serialFsmState = s_q.fsm;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // helper: cycles since last tick
   logic [16:0] gap_q;
   always_ff @(posedge clk) begin
      if (!resetn || s_q.tick) begin
         gap_q <= 17'h00001;
      end else begin
         gap_q <= gap_q + 17'h00001;
      end
   end

   // interval check only after a whole period with an unchanged reload
   logic [15:0] relSeen_q;
   logic armed_q;
   always_ff @(posedge clk) begin
      relSeen_q <= reloadValue;
      if (!resetn) begin
         armed_q <= 1'b0;
      end else if (reloadValue != relSeen_q) begin
         armed_q <= 1'b0;
      end else if (s_q.tick) begin
         armed_q <= 1'b1;
      end
   end

   property p_reload_high;
      wrLane && hit(adr_i, IDX_RELOAD_HIGH) |=> s_q.relHi == $past(dat_i[7:0]);
   endproperty
   a_reload_high: assert property (p_reload_high) else $error("high reload byte not stored");

   property p_irq_off_when_enabled;
      s_q.ctrlEn && $past(s_q.ctrlEn) |-> !timerIrq;
   endproperty
   a_irq_off_when_enabled: assert property (p_irq_off_when_enabled) else $error("timer irq while enabled");

   property p_irq_on_tick;
      s_q.count <= COUNT_ONE && !s_q.ctrlEn && s_q.irqEn |=> timerIrq && baudTick;
   endproperty
   a_irq_on_tick: assert property (p_irq_on_tick) else $error("timer irq missing");

   property p_interval;
      s_q.tick && armed_q && $past(reloadValue) > 16'h0001 |-> gap_q == {1'b0, $past(reloadValue)};
   endproperty
   a_interval: assert property (p_interval) else $error("tick interval wrong");

   property p_reload;
      s_q.count <= COUNT_ONE |=> s_q.count == $past(reloadValue);
   endproperty
   a_reload: assert property (p_reload) else $error("counter not reloaded");

   property p_readback_select_a_high;
      busReq && !we_i && s_q.diagSel && hit(adr_i, IDX_RELOAD_HIGH) |=> dat_o[7:0] == $past(s_q.count[15:8]);
   endproperty
   a_readback_select_a_high: assert property (p_readback_select_a_high) else $error("counter high not read back");

   property p_readback_select_a_low;
      busReq && !we_i && s_q.diagSel && hit(adr_i, IDX_RELOAD_LOW) |=> dat_o[7:0] == $past(s_q.count[7:0]);
   endproperty
   a_readback_select_a_low: assert property (p_readback_select_a_low) else $error("counter low not read back");

   property p_view_fields;
      busReq && !we_i && hit(adr_i, IDX_READBACK_SELECT_A_STATE) |=>
         dat_o[7:0] == {$past(s_q.sclSync[1]), $past(s_q.sdaSync[1]), $past(s_q.stopCount), $past(s_q.fsm)};
   endproperty
   a_view_fields: assert property (p_view_fields) else $error("diagnostic view wrong");

   property p_stop_pair;
      serialFsmState == ST_STOP1 && s_q.tick && s_q.ctrlEn |=> serialFsmState == ST_STOP2;
   endproperty
   a_stop_pair: assert property (p_stop_pair) else $error("stop not in two parts");

   property p_nak_only;
      $rose(serialFsmState == ST_DNAK) |-> $past(serialFsmState) == ST_DACK && $past(nack);
   endproperty
   a_nak_only: assert property (p_nak_only) else $error("nack state without nack");

   property p_ack_one_cycle;
      ack_o |=> !ack_o;
   endproperty
   a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack longer than one cycle");

   property p_ack_answer;
      busReq |=> ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");

   property p_reload_low;
      wrLane && hit(adr_i, IDX_RELOAD_LOW) |=> s_q.relLo == $past(dat_i[7:0]);
   endproperty
   a_reload_low: assert property (p_reload_low) else $error("low reload byte not stored");

   property p_idle_when_off;
      !s_q.ctrlEn |=> serialFsmState == ST_IDLE;
   endproperty
   a_idle_when_off: assert property (p_idle_when_off) else $error("sequencer busy while disabled");

   property p_view_readonly;
      wrLane && hit(adr_i, IDX_READBACK_SELECT_A_STATE) |=> $stable(s_q.relHi) && $stable(s_q.relLo) && $stable(s_q.ctrlEn);
   endproperty
   a_view_readonly: assert property (p_view_readonly) else $error("view write changed state");

   property p_stop_flag;
      s_q.stopCount == (serialFsmState == ST_STOP2);
   endproperty
   a_stop_flag: assert property (p_stop_flag) else $error("stop count flag wrong");

   property p_data_steps;
      serialFsmState inside {[ST_D7:ST_D1]} && s_q.tick && s_q.ctrlEn |=> serialFsmState == $past(serialFsmState) + 5'h01;
   endproperty
   a_data_steps: assert property (p_data_steps) else $error("data bit codes not successive");

   property p_d0_ack;
      serialFsmState == ST_D0 && s_q.tick && s_q.ctrlEn |=> serialFsmState == ST_DACK;
   endproperty
   a_d0_ack: assert property (p_d0_ack) else $error("data ack not after bit 0");

   property p_alsb_ack;
      serialFsmState == ST_ALSB && s_q.tick && s_q.ctrlEn |=> serialFsmState == ST_AACK;
   endproperty
   a_alsb_ack: assert property (p_alsb_ack) else $error("address ack not after address lsb");

   property p_start_ten;
      serialFsmState == ST_START && s_q.tick && s_q.ctrlEn && tenBitAddr |=> serialFsmState == ST_F7;
   endproperty
   a_start_ten: assert property (p_start_ten) else $error("ten-bit frame not at first byte bit 7");

   property p_start_seven;
      serialFsmState == ST_START && s_q.tick && s_q.ctrlEn && !tenBitAddr |=> serialFsmState == ST_A7;
   endproperty
   a_start_seven: assert property (p_start_seven) else $error("seven-bit frame not at address bit 7");

   property p_frw_ack;
      serialFsmState == ST_FRW && s_q.tick && s_q.ctrlEn |=> serialFsmState == ST_FACK;
   endproperty
   a_frw_ack: assert property (p_frw_ack) else $error("first byte ack not after its last bit");

   c_timer_irq: cover property (timerIrq);
   c_readback_select_a_read: cover property (busReq && s_q.diagSel && hit(adr_i, IDX_RELOAD_LOW));
   c_stop_seq: cover property (serialFsmState == ST_STOP2);
   c_ten_bit: cover property (serialFsmState == ST_FACK);
   c_data_nak: cover property (serialFsmState == ST_DNAK);

endmodule : i2cbg_core

// File: sim/i2cbg_target.sv
// two-wire target model: acknowledges by pulling data low, clock line active only in frames
// assumes the sequencer state code of the design on the same clock
module i2cbg_target
   import i2cbg_pkg::*;
(
   // clock
   input wire logic clk,
   // sequencer view and nack command
   input wire i2cbg_fsm_t state,
   input wire i2cbg_fsm_t nackAt,
   // line levels
   output logic sclLevel,
   output logic sdaLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   initial sclLevel = 1'b1;
   // pull-up holds the clock high between frames
   always @(posedge clk) sclLevel <= (state == ST_IDLE) ? 1'b1 : ~sclLevel;
   // released data line reads high through the pull-up
   always_comb sdaLevel = (state inside {ST_AACK, ST_FACK, ST_DACK}) ? (state == nackAt) : 1'b1;
endmodule : i2cbg_target

// File: sim/tb_top.sv
// self-checking bench: register map, timer, diagnostic readback and sequencer paths
// assumes the target model on the line side and a 125 MHz clock
module tb_top
   import i2cbg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic we; logic [15:0] adr; logic sel; logic [7:0] dat; logic [7:0] exp;} i2cbg_row_t;
   logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [15:0] adr = 16'h0000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic startReq = 1'b0, tenBit = 1'b0, stopReq = 1'b1, ctrlEn, tick, irq, scl, sda;
   i2cbg_fsm_t fsm, nackAt = ST_IDLE;
   int bad_count = 0, total_checks = 0, cycles = 0, n, k;
   logic [7:0] rd;
   logic [4:0] expQ[$];
   i2cbg_row_t rows[12] = '{
      '{1'b0, 16'h3d4c, 1'b1, 8'h00, 8'hff}, '{1'b0, 16'h3d50, 1'b1, 8'h00, 8'hff},
      '{1'b0, 16'h3d48, 1'b1, 8'h00, 8'h00}, '{1'b0, 16'h3d58, 1'b1, 8'h00, 8'h00},
      '{1'b1, 16'h3d4c, 1'b1, 8'h12, 8'h00}, '{1'b1, 16'h3d50, 1'b0, 8'h55, 8'h00},
      '{1'b0, 16'h3d50, 1'b1, 8'h00, 8'hff}, '{1'b1, 16'h3d50, 1'b1, 8'h34, 8'h00},
      '{1'b0, 16'h3d4c, 1'b1, 8'h00, 8'h12}, '{1'b1, 16'h3d54, 1'b1, 8'hff, 8'h00},
      '{1'b0, 16'h3d54, 1'b1, 8'h00, 8'hc0}, '{1'b0, 16'h3d60, 1'b1, 8'h00, 8'h00}};
   always #4 clk = ~clk;
   i2cbg_core DUT (.clk(clk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .clock_line_level(scl), .data_line_level(sda), .startReq(startReq),
      .tenBitAddr(tenBit), .stopReq(stopReq), .controllerEnable(ctrlEn), .baudTick(tick), .timerIrq(irq),
      .serialFsmState(fsm));
   i2cbg_target partner (.clk(clk), .state(fsm), .nackAt(nackAt), .sclLevel(scl), .sdaLevel(sda));
   task conclude();
      if (bad_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task wb(input logic w, input logic [15:0] a, input logic s, input logic [7:0] d);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= {3'b000, s}; wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      rd = rdat[7:0];
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task wait_irq(output int c);
      c = 0;
      do begin @(posedge clk); c++; end while (irq !== 1'b1);
   endtask : wait_irq
   // startReq is dropped once the frame leaves idle so that no second frame follows
   task run_seq(input logic ten, input i2cbg_fsm_t nk, input logic stp);
      i2cbg_fsm_t last;
      last = ST_IDLE; k = 0;
      tenBit <= ten; nackAt <= nk; stopReq <= stp; startReq <= 1'b1;
      while (k < expQ.size()) begin
         @(posedge clk);
         if (fsm !== last) begin
            last = fsm; startReq <= 1'b0;
            check("state", last, expQ[k]);
            k++;
            if (last == ST_STOP2) begin wb(1'b0, 16'h3d54, 1'b1, 8'h00); check("stopview", rd & 8'h3f, 8'h2d); end
            // two edges for the data line to pass the synchroniser
            if (last == ST_AACK) begin
               repeat (2) @(posedge clk);
               wb(1'b0, 16'h3d54, 1'b1, 8'h00);
               check("sdaview", rd[6], 1'b0);
            end
         end
      end
   endtask : run_seq
   always @(posedge clk) begin
      cycles++;
      if (cycles == 95000) begin bad_count++; conclude(); end
   end
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      check("fsm reset", fsm, ST_IDLE);
      foreach (rows[i]) begin
         wb(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat);
         if (!rows[i].we) check("row", rd, rows[i].exp);
      end
      wb(1'b1, 16'h3d4c, 1'b1, 8'h01); wb(1'b1, 16'h3d50, 1'b1, 8'h00);
      wb(1'b1, 16'h3d48, 1'b1, 8'h10);
      wait_irq(n);
      wait_irq(n);
      check("irq interval", n, 16'd256);
      wb(1'b1, 16'h3d58, 1'b1, 8'h01);
      wait_irq(n);
      wb(1'b0, 16'h3d4c, 1'b1, 8'h00); check("readback_select_a high", rd, 8'h00);
      wb(1'b0, 16'h3d50, 1'b1, 8'h00); check("readback_select_a low", rd, 8'hfc);
      wb(1'b1, 16'h3d58, 1'b1, 8'h00);
      wb(1'b0, 16'h3d4c, 1'b1, 8'h00); check("plain high", rd, 8'h01);
      wb(1'b1, 16'h3d48, 1'b1, 8'h90);
      n = 0; k = 0;
      repeat (512) begin @(posedge clk); n += (tick === 1'b1); k += (irq !== 1'b0); end
      check("enable", ctrlEn, 1'b1);
      check("ticks", n, 16'd2);
      check("irq when enabled", k, 16'd0);
      expQ = {5'h01};
      for (int s = 5'h19; s <= 5'h1f; s++) expQ.push_back(s[4:0]);
      expQ = {expQ, 5'h0f, 5'h0e};
      for (int s = 5'h02; s <= 5'h0a; s++) expQ.push_back(s[4:0]);
      expQ = {expQ, 5'h0c, 5'h0d, 5'h00};
      run_seq(1'b0, ST_IDLE, 1'b1);
      // nack at data ack adds the data nack state before the stop
      expQ[19] = 5'h0b;
      expQ[20] = 5'h0c;
      expQ[21] = 5'h0d;
      expQ.push_back(5'h00);
      run_seq(1'b0, ST_DACK, 1'b0);
      expQ = {5'h01};
      for (int s = 5'h10; s <= 5'h18; s++) expQ.push_back(s[4:0]);
      expQ = {expQ, 5'h0c, 5'h0d, 5'h00};
      run_seq(1'b1, ST_FACK, 1'b1);
      resetn <= 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      wb(1'b0, 16'h3d4c, 1'b1, 8'h00); check("reload after reset", rd, 8'hff);
      conclude();
   end
endmodule : tb_top
